// file: logic/glcw_writer.sv
// Pixel memory write path: swap, logic/compare merge, bit mask, address stepping
`timescale 1ns/1ps
`default_nettype none

module glcw_writer
   import glcw_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   // Configuration levels
   input wire logic [2:0] LOGIC_OP_SELECT,
   input wire logic [glcw_pkg::BYTE_W-1:0] COMPARE_VALUE,
   input wire logic BYTE_SWAP_ENABLE,
   input wire logic [glcw_pkg::WORD_W-1:0] WRITE_BIT_MASK,
   input wire logic ADDRESS_STEP_DIRECTION,
   input wire logic ADDRESS_INCREMENT,
   // Address counter load
   input wire logic AC_LOAD,
   input wire logic [glcw_pkg::ADDR_W-1:0] AC_LOAD_VALUE,
   // Host write words
   input wire logic HOST_WR_VALID,
   output logic HOST_WR_READY,
   input wire logic [glcw_pkg::WORD_W-1:0] HOST_WR_DATA,
   // Pixel memory port, read data one cycle after the read strobe
   output logic [glcw_pkg::ADDR_W-1:0] PIXEL_MEMORY_ADDR,
   output logic PIXEL_MEMORY_RD,
   input wire logic [glcw_pkg::WORD_W-1:0] PIXEL_MEMORY_RDATA,
   output logic PIXEL_MEMORY_WR,
   output logic [glcw_pkg::WORD_W-1:0] PIXEL_MEMORY_WDATA,
   output logic [glcw_pkg::WORD_W-1:0] PIXEL_MEMORY_BIT_EN,
   // Status
   output logic [glcw_pkg::ADDR_W-1:0] ADDRESS_COUNTER,
   output logic [glcw_pkg::WORD_W-1:0] READ_LATCH,
   output logic BUSY
);
   import glcw_pkg::*;

   glcw_state_e state_q;
   glcw_state_e state_d;
   logic buf_valid;
   logic buf_ready;
   logic [WORD_W-1:0] buf_data;
   logic take;
   logic [WORD_W-1:0] swapped;
   logic need_read;
   logic [2:0] op_q;
   logic step_vert_q;
   logic step_inc_q;
   logic [WORD_W-1:0] host_q;
   logic [WORD_W-1:0] latch_q;
   logic [WORD_W-1:0] orig;
   logic used_latch_q;
   logic rd_q;
   logic wr_q;
   logic [WORD_W-1:0] wdata_q;
   logic [WORD_W-1:0] bit_en_q;
   logic [ADDR_W-1:0] ac_q;
   logic [ADDR_W-1:0] ac_d;
   logic [WORD_W-1:0] merged;
   logic [WORD_W-1:0] masked;
   logic [BYTES-1:0] byte_ok;
   logic [WORD_W-1:0] new_bit_en;
   logic [7:0] col;
   logic [7:0] row;

   // Stall absorber so a word arriving during a merge is not dropped
   glcw_buf u_buf (
      .clk(CLK),
      .rst_n(RST_N),
      .in_valid(HOST_WR_VALID),
      .in_ready(HOST_WR_READY),
      .in_data(HOST_WR_DATA),
      .out_valid(buf_valid),
      .out_ready(buf_ready),
      .out_data(buf_data)
   );

   // Sequencer pulls one word only when idle
   assign buf_ready = (state_q == GLCW_IDLE);
   assign take = buf_valid && buf_ready;

   // Swap happens first, before any merge
   assign swapped = BYTE_SWAP_ENABLE ? {buf_data[BYTE_W-1:0], buf_data[WORD_W-1:BYTE_W]}
                                     : buf_data;

   // Only logic codes and original-compare codes touch memory for reading
   always_comb
   begin
      case (LOGIC_OP_SELECT)
         LOP_REPLACE,
         LOP_HOST_EQ,
         LOP_HOST_NE:
            need_read = 1'b0;
         default:
            need_read = 1'b1;
      endcase
   end

   // Original word straight off the memory port; it only stands in the MERGE
   // cycle, one cycle after the read strobe, so the merge takes it there
   // and the latch keeps a copy for the status port
   assign orig = PIXEL_MEMORY_RDATA;

   // Next state
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         GLCW_IDLE:
         begin
            if (take)
               state_d = need_read ? GLCW_FETCH : GLCW_MERGE;
         end
         GLCW_FETCH:
            state_d = GLCW_MERGE;
         GLCW_MERGE:
            state_d = GLCW_COMMIT;
         GLCW_COMMIT:
            state_d = GLCW_IDLE;
         default:
            state_d = GLCW_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
         state_q <= GLCW_IDLE;
      else
         state_q <= state_d;
   end

   // Capture word and mode at acceptance so later config changes, other than mask and compare value, do not tear it
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         host_q <= WORD_RESET;
         op_q <= LOP_REPLACE;
         step_vert_q <= 1'b0;
         step_inc_q <= 1'b0;
         used_latch_q <= 1'b0;
      end
      else if (take)
      begin
         host_q <= swapped;
         op_q <= LOGIC_OP_SELECT;
         step_vert_q <= ADDRESS_STEP_DIRECTION;
         step_inc_q <= ADDRESS_INCREMENT;
         used_latch_q <= need_read;
      end
   end

   // Internal read strobe, high for the one cycle after acceptance of a code that reads
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
         rd_q <= 1'b0;
      else
         rd_q <= take && need_read;
   end

   // Read latch: original word kept inside, never sent back to the host
   // Write-only codes leave it alone; their memory bus shows nothing useful
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
         latch_q <= WORD_RESET;
      else if ((state_q == GLCW_MERGE) && used_latch_q)
         latch_q <= orig;
   end

   // Per-byte compare and logic merge
   // Byte 0 is bits 7:0, byte 1 bits 15:8, each judged on its own
   genvar gb;
   generate
      for (gb = 0; gb < BYTES; gb++)
      begin : g_byte
         logic [BYTE_W-1:0] h_byte;
         logic [BYTE_W-1:0] o_byte;
         logic [BYTE_W-1:0] src_byte;
         logic hit;
         assign h_byte = host_q[gb*BYTE_W +: BYTE_W];
         assign o_byte = orig[gb*BYTE_W +: BYTE_W];
         // Compare source: host byte for 11x, original byte for 10x
         assign src_byte = op_q[LOP_SRC_BIT] ? h_byte : o_byte;
         assign hit = (src_byte == COMPARE_VALUE) ^ op_q[LOP_INV_BIT];
         // Non-compare codes always pass the byte
         assign byte_ok[gb] = op_q[LOP_COND_BIT] ? hit : 1'b1;
      end
   endgenerate

   // Logic operation between the original word off the memory port and host word
   always_comb
   begin
      case (op_q)
         LOP_OR:
            merged = orig | host_q;
         LOP_AND:
            merged = orig & host_q;
         LOP_XOR:
            merged = orig ^ host_q;
         default:
            merged = host_q;
      endcase
   end

   // Mask last: cleared mask bits take the new bit, set bits keep the stored one
   assign new_bit_en = ~WRITE_BIT_MASK &
                       {{BYTE_W{byte_ok[1]}}, {BYTE_W{byte_ok[0]}}};
   // With a fresh original in hand, held bits are rewritten with it; else bit enables hold
   assign masked = used_latch_q ? ((merged & new_bit_en) | (orig & ~new_bit_en))
                                : merged;

   // Write strobe and data registered for one cycle in COMMIT
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         wr_q <= 1'b0;
         wdata_q <= WORD_RESET;
         bit_en_q <= WORD_RESET;
      end
      else if (state_q == GLCW_MERGE)
      begin
         wr_q <= 1'b1;
         wdata_q <= masked;
         bit_en_q <= new_bit_en;
      end
      else
      begin
         wr_q <= 1'b0;
      end
   end

   // Next address after a write
   assign col = ac_q[AC_COL_LSB +: 8];
   assign row = ac_q[AC_ROW_LSB +: 8];
   always_comb
   begin
      ac_d = ac_q;
      if (!step_vert_q)
      begin
         // Horizontal: wrap at a side edge to the next row
         if (step_inc_q)
         begin
            if (col == AC_COL_LAST)
               ac_d = {((row == AC_ROW_LAST) ? 8'h00 : row + 8'h01), 8'h00};
            else
               ac_d = ac_q + 16'h0001;
         end
         else
         begin
            if (col == 8'h00)
               ac_d = {((row == AC_ROW_LAST) ? 8'h00 : row + 8'h01), AC_COL_LAST};
            else
               ac_d = ac_q - 16'h0001;
         end
      end
      else
      begin
         // Vertical: down one row, past the bottom to the top of the adjacent column
         if (row == AC_ROW_LAST)
         begin
            if (step_inc_q)
               ac_d = {8'h00, ((col == AC_COL_LAST) ? 8'h00 : col + 8'h01)};
            else
               ac_d = {8'h00, ((col == 8'h00) ? AC_COL_LAST : col - 8'h01)};
         end
         else
         begin
            ac_d = ac_q + AC_ROW_STEP;
         end
      end
   end

   // Address counter; a load from outside beats the automatic step
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
         ac_q <= AC_RESET;
      else if (AC_LOAD)
         ac_q <= AC_LOAD_VALUE;
      else if (state_q == GLCW_COMMIT)
         ac_q <= ac_d;
   end

   // Port drive
   assign PIXEL_MEMORY_ADDR = ac_q;
   assign PIXEL_MEMORY_RD = rd_q;
   assign PIXEL_MEMORY_WR = wr_q;
   assign PIXEL_MEMORY_WDATA = wdata_q;
   assign PIXEL_MEMORY_BIT_EN = bit_en_q;

   // Status view; the latch is for observation only
   assign ADDRESS_COUNTER = ac_q;
   assign READ_LATCH = latch_q;
   assign BUSY = (state_q != GLCW_IDLE) || buf_valid;

endmodule // glcw_writer

`default_nettype wire

// file: logic/glcw_pkg.sv
// Constants and types shared by the pixel memory write path
package glcw_pkg;

   localparam int unsigned WORD_W = 16;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned BYTES = 2;
   localparam int unsigned ADDR_W = 16;

   // Logic operation select codes
   localparam logic [2:0] LOP_REPLACE = 3'h0;
   localparam logic [2:0] LOP_OR = 3'h1;
   localparam logic [2:0] LOP_AND = 3'h2;
   localparam logic [2:0] LOP_XOR = 3'h3;
   localparam logic [2:0] LOP_ORIG_EQ = 3'h4;
   localparam logic [2:0] LOP_ORIG_NE = 3'h5;
   localparam logic [2:0] LOP_HOST_EQ = 3'h6;
   localparam logic [2:0] LOP_HOST_NE = 3'h7;

   // Field positions inside the logic operation select
   localparam int unsigned LOP_COND_BIT = 2;
   localparam int unsigned LOP_SRC_BIT = 1;
   localparam int unsigned LOP_INV_BIT = 0;

   // Address counter layout: low byte column, high byte row
   localparam int unsigned AC_COL_LSB = 0;
   localparam int unsigned AC_ROW_LSB = 8;
   localparam logic [7:0] AC_COL_LAST = 8'h33;
   localparam logic [7:0] AC_ROW_LAST = 8'h4F;
   localparam logic [15:0] AC_ROW_STEP = 16'h0100;
   localparam logic [15:0] AC_RESET = 16'h0000;

   // Reset values of datapath registers
   localparam logic [15:0] WORD_RESET = 16'h0000;

   // Write sequencer states
   typedef enum logic [1:0]
   {
      GLCW_IDLE = 2'b00,
      GLCW_FETCH = 2'b01,
      GLCW_MERGE = 2'b10,
      GLCW_COMMIT = 2'b11
   } glcw_state_e;

endpackage : glcw_pkg

// file: logic/glcw_buf.sv
// Two-entry buffer between host write strobes and the write sequencer
`timescale 1ns/1ps
`default_nettype none

module glcw_buf
   import glcw_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [glcw_pkg::WORD_W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [glcw_pkg::WORD_W-1:0] out_data
);
   import glcw_pkg::*;

   logic [WORD_W-1:0] slot_q [0:1];
   logic rd_ptr_q;
   logic wr_ptr_q;
   logic [1:0] count_q;
   logic push;
   logic pop;

   // Honest full and empty flags from the occupancy count
   assign in_ready = (count_q != 2'd2);
   assign out_valid = (count_q != 2'd0);
   assign out_data = slot_q[rd_ptr_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Storage slots; data reset to WORD_RESET, though the flags guard them
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         slot_q[0] <= WORD_RESET;
         slot_q[1] <= WORD_RESET;
      end
      else if (push)
      begin
         slot_q[wr_ptr_q] <= in_data;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rd_ptr_q <= 1'b0;
         wr_ptr_q <= 1'b0;
         count_q <= 2'd0;
      end
      else
      begin
         if (push)
            wr_ptr_q <= ~wr_ptr_q;
         if (pop)
            rd_ptr_q <= ~rd_ptr_q;
         if (push && !pop)
            count_q <= count_q + 2'd1;
         else if (pop && !push)
            count_q <= count_q - 2'd1;
      end
   end

endmodule // glcw_buf

`default_nettype wire

// file: sim/glcw_pmem.sv
// Behavioural pixel memory standing at the far side of the write path
`timescale 1ns/1ps
`default_nettype none
module glcw_pmem
(
   input wire logic clk,
   input wire logic [15:0] addr,
   input wire logic rd,
   input wire logic wr,
   input wire logic [15:0] wdata,
   input wire logic [15:0] bit_en,
   output logic [15:0] rdata
);
   logic [15:0] m [0:65535];
   // One-cycle read latency; outside that cycle the bus shows junk
   always @(posedge clk)
   begin
      rdata <= rd ? m[addr] : ~m[addr];
      if (wr)
         m[addr] <= (m[addr] & ~bit_en) | (wdata & bit_en);
   end
endmodule // glcw_pmem
`default_nettype wire

// file: sim/glcw_writer_monitor.sv
// Port-level assertions for the pixel memory write path
`timescale 1ns/1ps
`default_nettype none
module glcw_writer_monitor
   import glcw_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [2:0] LOGIC_OP_SELECT,
   input wire logic [7:0] COMPARE_VALUE,
   input wire logic [15:0] WRITE_BIT_MASK,
   input wire logic ADDRESS_STEP_DIRECTION,
   input wire logic ADDRESS_INCREMENT,
   input wire logic AC_LOAD,
   input wire logic [15:0] PIXEL_MEMORY_ADDR,
   input wire logic PIXEL_MEMORY_RD,
   input wire logic [15:0] PIXEL_MEMORY_RDATA,
   input wire logic PIXEL_MEMORY_WR,
   input wire logic [15:0] PIXEL_MEMORY_BIT_EN,
   input wire logic [15:0] PIXEL_MEMORY_WDATA,
   input wire logic [15:0] ADDRESS_COUNTER,
   input wire logic [15:0] READ_LATCH
);
   import glcw_pkg::*;
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   // Short aliases; config is held steady by the host while a word is in flight
   wire wr = PIXEL_MEMORY_WR;
   wire [2:0] op = LOGIC_OP_SELECT;
   wire [15:0] be = PIXEL_MEMORY_BIT_EN;
   wire [15:0] la = READ_LATCH;
   wire [15:0] ac = ADDRESS_COUNTER;
   wire step = wr && !AC_LOAD;
   property p_fetch;
      PIXEL_MEMORY_RD |-> ##2 (wr && PIXEL_MEMORY_ADDR == $past(PIXEL_MEMORY_ADDR, 2)
         && la == $past(PIXEL_MEMORY_RDATA));
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch not merged");
   property p_rd_codes;
      wr |-> $past(PIXEL_MEMORY_RD, 2) == (op inside {[3'h1:3'h5]});
   endproperty
   a_rd_codes: assert property (p_rd_codes) else $error("bad read use");
   property p_mask;
      wr |-> (be & WRITE_BIT_MASK) == 16'h0000;
   endproperty
   a_mask: assert property (p_mask) else $error("masked bit written");
   property p_replace;
      wr && op == LOP_REPLACE |-> be == ~WRITE_BIT_MASK;
   endproperty
   a_replace: assert property (p_replace) else $error("replace enables");
   property p_or;
      wr && op == LOP_OR |-> (PIXEL_MEMORY_WDATA & la) == la;
   endproperty
   a_or: assert property (p_or) else $error("or lost bits");
   property p_orig_eq;
      wr && op == LOP_ORIG_EQ && la[7:0] != COMPARE_VALUE |-> be[7:0] == 8'h00;
   endproperty
   a_orig_eq: assert property (p_orig_eq) else $error("eq byte written");
   property p_orig_ne;
      wr && op == LOP_ORIG_NE && la[15:8] == COMPARE_VALUE |-> be[15:8] == 8'h00;
   endproperty
   a_orig_ne: assert property (p_orig_ne) else $error("ne byte written");
   property p_hstep;
      step && !ADDRESS_STEP_DIRECTION && ADDRESS_INCREMENT && ac[7:0] != AC_COL_LAST
         |=> ac == $past(ac) + 16'h0001;
   endproperty
   a_hstep: assert property (p_hstep) else $error("bad column step");
   property p_vstep;
      step && ADDRESS_STEP_DIRECTION && ac[15:8] != AC_ROW_LAST |=> ac == $past(ac) + AC_ROW_STEP;
   endproperty
   a_vstep: assert property (p_vstep) else $error("bad row step");
   // Main scenarios
   c_rmw: cover property (PIXEL_MEMORY_RD);
   c_host_ne: cover property (wr && op == LOP_HOST_NE);
   c_wrap: cover property (wr ##1 ac == AC_RESET);
endmodule // glcw_writer_monitor
bind glcw_writer glcw_writer_monitor u_mon (
   .CLK(CLK),
   .RST_N(RST_N),
   .LOGIC_OP_SELECT(LOGIC_OP_SELECT),
   .COMPARE_VALUE(COMPARE_VALUE),
   .WRITE_BIT_MASK(WRITE_BIT_MASK),
   .ADDRESS_STEP_DIRECTION(ADDRESS_STEP_DIRECTION),
   .ADDRESS_INCREMENT(ADDRESS_INCREMENT),
   .AC_LOAD(AC_LOAD),
   .PIXEL_MEMORY_ADDR(PIXEL_MEMORY_ADDR),
   .PIXEL_MEMORY_RD(PIXEL_MEMORY_RD),
   .PIXEL_MEMORY_RDATA(PIXEL_MEMORY_RDATA),
   .PIXEL_MEMORY_WR(PIXEL_MEMORY_WR),
   .PIXEL_MEMORY_BIT_EN(PIXEL_MEMORY_BIT_EN),
   .PIXEL_MEMORY_WDATA(PIXEL_MEMORY_WDATA),
   .ADDRESS_COUNTER(ADDRESS_COUNTER),
   .READ_LATCH(READ_LATCH)
);
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the pixel memory write path
`timescale 1ns/1ps
`default_nettype none
module tb;
   import glcw_pkg::*;
   logic clk, rst_n, byte_swap_enable, dir, inc, ld, v, rdy, rd, wr, busy, full;
   logic [2:0] op;
   logic [7:0] cmp;
   logic [15:0] msk, lda, hd, adr, rdat, wdat, ben, ac, lat, eac;
   logic [15:0] e [4];
   int err_count, check_count, cyc;
   glcw_writer dut (.CLK(clk), .RST_N(rst_n), .LOGIC_OP_SELECT(op), .COMPARE_VALUE(cmp),
      .BYTE_SWAP_ENABLE(byte_swap_enable), .WRITE_BIT_MASK(msk), .ADDRESS_STEP_DIRECTION(dir),
      .ADDRESS_INCREMENT(inc), .AC_LOAD(ld), .AC_LOAD_VALUE(lda), .HOST_WR_VALID(v),
      .HOST_WR_READY(rdy), .HOST_WR_DATA(hd), .PIXEL_MEMORY_ADDR(adr), .PIXEL_MEMORY_RD(rd),
      .PIXEL_MEMORY_RDATA(rdat), .PIXEL_MEMORY_WR(wr), .PIXEL_MEMORY_WDATA(wdat),
      .PIXEL_MEMORY_BIT_EN(ben), .ADDRESS_COUNTER(ac), .READ_LATCH(lat), .BUSY(busy));
   glcw_pmem mem (.clk(clk), .addr(adr), .rd(rd), .wr(wr), .wdata(wdat), .bit_en(ben),
      .rdata(rdat));
   // Expected stored word: swap, merge, per-byte condition, then mask
   function automatic logic [15:0] calc(input logic [15:0] o, input logic [15:0] h);
      logic [15:0] s, n, w;
      logic [7:0] src;
      s = byte_swap_enable ? {h[7:0], h[15:8]} : h;
      n = op == LOP_OR ? o | s : op == LOP_AND ? o & s : op == LOP_XOR ? o ^ s : s;
      for (int b = 0; b < 2; b++)
      begin
         src = op[1] ? s[8*b+:8] : o[8*b+:8];
         w[8*b+:8] = (!op[2] || ((src == cmp) != op[0])) ? ~msk[8*b+:8] : 8'h00;
      end
      return (o & ~w) | (n & w);
   endfunction
   // Expected counter after one write, edges wrapping as described
   function automatic logic [15:0] nxt(input logic [15:0] a);
      logic [7:0] c, r, cs;
      c = a[7:0];
      r = a[15:8];
      // Column after one sideways step, wrapping at either side
      cs = c == (inc ? AC_COL_LAST : 8'h00) ? (inc ? 8'h00 : AC_COL_LAST)
         : c + (inc ? 8'h01 : 8'hFF);
      if (!dir && c == (inc ? AC_COL_LAST : 8'h00))
         r = r == AC_ROW_LAST ? 8'h00 : r + 8'h01;
      if (!dir)
         c = cs;
      else if (r != AC_ROW_LAST)
         r = r + 8'h01;
      else
      begin
         r = 8'h00;
         c = cs;
      end
      return {r, c};
   endfunction
   task automatic chk(input logic [15:0] g, input logic [15:0] x);
      check_count++;
      if (g !== x)
      begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, g, x);
      end
   endtask
   task automatic cfg(input logic [2:0] o, input logic s, input logic [15:0] m, input logic d);
      op = o;
      byte_swap_enable = s;
      msk = m;
      dir = d;
   endtask
   task automatic load(input logic [15:0] a);
      ld = 1'h1;
      lda = a;
      @(posedge clk);
      #1;
      ld = 1'h0;
      eac = a;
   endtask
   // Hold the word until the buffer accepts it; the host gives up after 20 waiting cycles
   task automatic push(input logic [15:0] h);
      hd = h;
      v = 1'h1;
      for (int n = 0; rdy !== 1'h1 && n < 20; n++)
      begin
         full = 1'h1;
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      #1;
   endtask
   task automatic idle;
      for (int n = 0; busy !== 1'h0 && n < 40; n++)
      begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic one(input logic [15:0] h);
      logic [15:0] a, o;
      a = eac;
      o = mem.m[a];
      push(h);
      v = 1'h0;
      idle();
      eac = nxt(a);
      chk(mem.m[a], calc(o, h));
      chk(ac, eac);
      if (op inside {[3'h1:3'h5]})
         chk(lat, o);
   endtask
   task automatic report_and_stop;
      $display("Checks %0d, errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   // Cut a hang short
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_count++;
         report_and_stop();
      end
   end
   initial
   begin
      rst_n = 1'h0;
      v = 1'h0;
      hd = 16'h0000;
      ld = 1'h0;
      lda = 16'h0000;
      cmp = 8'h34;
      inc = 1'h1;
      full = 1'h0;
      cfg(LOP_REPLACE, 1'h0, 16'h0000, 1'h0);
      for (int i = 0; i < 65536; i++)
         mem.m[i] = 16'(i) ^ 16'hC35A;
      repeat (3) @(posedge clk);
      #1;
      rst_n = 1'h1;
      chk(ac, AC_RESET);
      // Every code, with and without swap, one byte matching the compare value
      load(16'h1000);
      for (int k = 0; k < 16; k++)
      begin
         cfg(3'(k >> 1), k[0], 16'h0F00, 1'h0);
         mem.m[eac] = 16'h3412;
         one(16'h5634);
      end
      // Edge wraps in all four stepping modes, then one plain step
      for (int k = 0; k < 4; k++)
      begin
         cfg(3'(k), 1'h0, 16'h00F0, k[1]);
         inc = ~k[0];
         load(k[0] ? 16'h4F00 : 16'h4F33);
         one(16'h9ABC);
         one(16'h0F0F);
      end
      // Back-to-back words must queue while the sequencer works
      cfg(LOP_XOR, 1'h1, 16'h0000, 1'h0);
      inc = 1'h1;
      load(16'h2000);
      for (int i = 0; i < 4; i++)
         e[i] = calc(mem.m[16'h2000 + i], 16'h1357 + 16'(i));
      for (int i = 0; i < 4; i++)
         push(16'h1357 + 16'(i));
      v = 1'h0;
      idle();
      for (int i = 0; i < 4; i++)
         chk(mem.m[16'h2000 + i], e[i]);
      chk(ac, 16'h2004);
      chk({15'h0000, full}, 16'h0001);
      report_and_stop();
   end
endmodule // tb
`default_nettype wire
